// *** sdst_pkg.sv ***
// Constants, register map and field layout for the serial DMA status tracker.
// Assumes a 32-bit plain register port and one 50 MHz system clock.
package sdst_pkg;
    localparam int unsigned AW = 14;
    localparam int unsigned IRQ_W = 5;
    localparam logic [1:0][31:0] OFS_RX_BEG = {32'h4000_c808, 32'h4000_c800};
    localparam logic [1:0][31:0] OFS_RX_END = {32'h4000_c80c, 32'h4000_c804};
    localparam logic [1:0][31:0] OFS_TX_BEG = {32'h4000_c818, 32'h4000_c810};
    localparam logic [1:0][31:0] OFS_TX_END = {32'h4000_c81c, 32'h4000_c814};
    localparam logic [31:0] OFS_RX_SAVED = 32'h4000_c820;
    localparam logic [31:0] OFS_STATUS = 32'h4000_c82c;
    localparam logic [31:0] OFS_CTRL = 32'h4000_c830;
    localparam logic [31:0] OFS_IRQ_STAT = 32'h4000_c840;
    localparam logic [31:0] OFS_IRQ_MASK = 32'h4000_c844;
    // Address registers carry a fixed RAM base bit above the field
    localparam logic [31:0] ADDR_FIXED = 32'h2000_0000;
    localparam logic [AW-1:0] ADDR_RESET = 14'h0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam int unsigned ST_SSEL_LSB = 10;
    localparam int unsigned ST_FRM_LSB = 8;
    localparam int unsigned ST_PAR_LSB = 6;
    localparam int unsigned ST_OVF_LSB = 4;
    localparam int unsigned ST_TXACT_LSB = 2;
    localparam int unsigned ST_RXACT_LSB = 0;
    localparam int unsigned CT_RX_LOAD_LSB = 0;
    localparam int unsigned CT_TX_LOAD_LSB = 2;
    localparam int unsigned CT_RX_RST = 4;
    localparam int unsigned CT_TX_RST = 5;
    localparam int unsigned IRQ_RX_UNLOAD_LSB = 0;
    localparam int unsigned IRQ_TX_UNLOAD_LSB = 2;
    localparam int unsigned IRQ_SSEL = 4;
    typedef enum logic [2:0] {
        SDST_SSEL_NONE = 3'b000,
        SDST_SSEL_A_ONCE = 3'b010,
        SDST_SSEL_B_ONCE = 3'b011,
        SDST_SSEL_A_MULTI = 3'b110,
        SDST_SSEL_B_MULTI = 3'b111
    } sdst_ssel_t;
endpackage

// *** sdst_chan_if.sv ***
// Control and status bundle between the tracker top and one A/B buffer channel.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface sdst_chan_if;
    import sdst_pkg::*;
    logic [1:0] load;
    logic chan_rst;
    logic take;
    logic [1:0][AW-1:0] beg;
    logic [1:0][AW-1:0] last;
    logic [1:0] active;
    logic [1:0] loaded;
    logic [1:0] unload;
    logic [1:0][AW-1:0] cnt;
    modport ctl (output load, chan_rst, take, beg, last, input active, loaded, unload, cnt);
    modport chan (input load, chan_rst, take, beg, last, output active, loaded, unload, cnt);
endinterface

// *** sdst_chan.sv ***
// One DMA channel with two buffers: load, activation order, counting, unload.
// Assumes load, reset and take are single-cycle pulses from the same clock.
`timescale 1ns/10ps
module sdst_chan
    import sdst_pkg::*;
(
    // System
    input wire logic i_clk,
    input wire logic i_reset,
    // Channel bundle
    sdst_chan_if.chan bus
);
    logic [1:0] loaded_q;
    logic [1:0] active_q;
    logic [1:0] active_d;
    logic [1:0][AW-1:0] cnt_q;
    logic [1:0] done;
    logic [1:0] cur;
    logic [1:0] avail;

    // Extra bit keeps the sum from wrapping at the top of the address range
    function automatic logic past_end(input logic [AW-1:0] b, input logic [AW-1:0] c,
                                      input logic [AW-1:0] e);
        return ({1'b0, b} + {1'b0, c}) > {1'b0, e};
    endfunction

    for (genvar i = 0; i < 2; i++) begin : g_buf
        assign done[i] = loaded_q[i] & ~bus.load[i] & past_end(bus.beg[i], cnt_q[i], bus.last[i]);

        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                cnt_q[i] <= ADDR_RESET;
            end else if (bus.chan_rst || bus.load[i]) begin
                cnt_q[i] <= ADDR_RESET;
            end else if (bus.take && active_q[i]) begin
                cnt_q[i] <= cnt_q[i] + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            loaded_q <= 2'b00;
        end else if (bus.chan_rst) begin
            loaded_q <= 2'b00;
        end else begin
            loaded_q <= (loaded_q & ~done) | bus.load;
        end
    end

    always_comb begin
        cur = active_q & loaded_q & ~done;
        avail = (loaded_q & ~done) | bus.load;
        if (cur != 2'b00) begin
            active_d = cur;
        end else if (avail == 2'b11) begin
            // Alternate after a finished buffer; from idle A goes first
            active_d = active_q[0] ? 2'b10 : 2'b01;
        end else begin
            active_d = avail;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            active_q <= 2'b00;
        end else if (bus.chan_rst) begin
            active_q <= 2'b00;
        end else begin
            active_q <= active_d;
        end
    end

    assign bus.active = active_q;
    assign bus.loaded = loaded_q;
    assign bus.unload = done;
    assign bus.cnt = cnt_q;
endmodule

// *** sdst_errflag.sv ***
// Frame, parity and overrun flags of one receive buffer.
// Assumes take and clear are single-cycle pulses from the same clock.
`timescale 1ns/10ps
module sdst_errflag (
    // System
    input wire logic i_clk,
    input wire logic i_reset,
    // Events
    input wire logic i_clear,
    input wire logic i_take,
    input wire logic i_frame,
    input wire logic i_parity,
    input wire logic i_overrun,
    input wire logic i_uart_ok,
    // Flags: frame, parity, overrun
    output logic [2:0] o_flags
);
    logic [2:0] flags_q;
    logic [2:0] set;

    assign set = {i_take & i_uart_ok & i_frame, i_take & i_uart_ok & i_parity, i_take & i_overrun};

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            flags_q <= 3'b000;
        end else if (i_clear) begin
            flags_q <= 3'b000;
        end else begin
            flags_q <= flags_q | set;
        end
    end

    assign o_flags = flags_q;
endmodule

// *** sdst_top.sv ***
// Serial DMA status tracker: register port, both A/B channels, status word.
// Assumes FIFO strobes on the system clock; slave select arrives from a pin.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module sdst_top
    import sdst_pkg::*;
#(
    parameter bit FIRST_CONTROLLER = 1'b1
) (
    // System
    input wire logic i_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [31:0] o_rdata,
    // Receive FIFO side
    input wire logic i_rx_take,
    input wire logic i_rx_frame_err,
    input wire logic i_rx_parity_err,
    input wire logic i_rx_overrun,
    // Transmit FIFO side
    input wire logic i_tx_take,
    // Mode and pin
    input wire logic i_uart_mode,
    input wire logic i_spi_slave_mode,
    input wire logic i_slave_select_n,
    // Buffer state
    output logic [1:0] o_rx_active,
    output logic [1:0] o_tx_active,
    output logic [AW-1:0] o_rx_count,
    output logic [AW-1:0] o_tx_count,
    // Interrupt
    output logic o_irq
);
    sdst_chan_if rx_if ();
    sdst_chan_if tx_if ();

    logic [1:0][AW-1:0] rx_beg_q;
    logic [1:0][AW-1:0] rx_end_q;
    logic [1:0][AW-1:0] tx_beg_q;
    logic [1:0][AW-1:0] tx_end_q;
    logic rx_rst_q;
    logic tx_rst_q;
    logic [1:0] rx_load;
    logic [1:0] tx_load;
    logic ctrl_wr;
    logic ssel_meta_q;
    logic ssel_sync_q;
    logic ssel_prev_q;
    logic deselect;
    sdst_ssel_t ssel_q;
    logic [AW-1:0] saved_cnt_q;
    logic [1:0][2:0] err_flags;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_evt;
    logic [31:0] status;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [AW-1:0] rx_cnt_sel;
    logic [AW-1:0] tx_cnt_sel;
    logic uart_ok;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic [31:0] addr_word(input logic [AW-1:0] f);
        return ADDR_FIXED | {{(32 - AW){1'b0}}, f};
    endfunction

    // Slave select pin: two stages before any logic looks at it
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ssel_meta_q <= 1'b1;
            ssel_sync_q <= 1'b1;
            ssel_prev_q <= 1'b1;
        end else begin
            ssel_meta_q <= i_slave_select_n;
            ssel_sync_q <= ssel_meta_q;
            ssel_prev_q <= ssel_sync_q;
        end
    end

    assign deselect = i_spi_slave_mode & ssel_sync_q & ~ssel_prev_q;

    // Control writes; load and reset requests are single-cycle
    assign ctrl_wr = i_write & hit(i_addr, OFS_CTRL);
    assign rx_load = ctrl_wr ? i_wdata[CT_RX_LOAD_LSB +: 2] : 2'b00;
    assign tx_load = ctrl_wr ? i_wdata[CT_TX_LOAD_LSB +: 2] : 2'b00;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_rst_q <= 1'b0;
            tx_rst_q <= 1'b0;
        end else begin
            rx_rst_q <= ctrl_wr & i_wdata[CT_RX_RST];
            tx_rst_q <= ctrl_wr & i_wdata[CT_TX_RST];
        end
    end

    // Start and end address registers of both channels
    for (genvar i = 0; i < 2; i++) begin : g_addr
        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                rx_beg_q[i] <= ADDR_RESET;
                rx_end_q[i] <= ADDR_RESET;
                tx_beg_q[i] <= ADDR_RESET;
                tx_end_q[i] <= ADDR_RESET;
            end else if (i_write) begin
                if (hit(i_addr, OFS_RX_BEG[i])) begin
                    rx_beg_q[i] <= i_wdata[AW-1:0];
                end
                if (hit(i_addr, OFS_RX_END[i])) begin
                    rx_end_q[i] <= i_wdata[AW-1:0];
                end
                if (hit(i_addr, OFS_TX_BEG[i])) begin
                    tx_beg_q[i] <= i_wdata[AW-1:0];
                end
                if (hit(i_addr, OFS_TX_END[i])) begin
                    tx_end_q[i] <= i_wdata[AW-1:0];
                end
            end
        end
    end

    assign rx_if.load = rx_load;
    assign rx_if.chan_rst = rx_rst_q;
    assign rx_if.take = i_rx_take;
    assign rx_if.beg = rx_beg_q;
    assign rx_if.last = rx_end_q;
    assign tx_if.load = tx_load;
    assign tx_if.chan_rst = tx_rst_q;
    assign tx_if.take = i_tx_take;
    assign tx_if.beg = tx_beg_q;
    assign tx_if.last = tx_end_q;

    sdst_chan u_rx_chan (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .bus(rx_if.chan)
    );

    sdst_chan u_tx_chan (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .bus(tx_if.chan)
    );

    assign rx_cnt_sel = rx_if.active[1] ? rx_if.cnt[1] : rx_if.cnt[0];
    assign tx_cnt_sel = tx_if.active[1] ? tx_if.cnt[1] : tx_if.cnt[0];

    // Frame and parity flags exist only where the receiver can mark bytes
    assign uart_ok = FIRST_CONTROLLER & i_uart_mode;

    for (genvar i = 0; i < 2; i++) begin : g_err
        sdst_errflag u_err (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_clear(rx_load[i] | rx_rst_q),
            .i_take(i_rx_take & rx_if.active[i]),
            .i_frame(i_rx_frame_err),
            .i_parity(i_rx_parity_err),
            .i_overrun(i_rx_overrun),
            .i_uart_ok(uart_ok),
            .o_flags(err_flags[i])
        );
    end

    // Count saved at deselect; a deselect with no active buffer saves nothing
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ssel_q <= SDST_SSEL_NONE;
            saved_cnt_q <= ADDR_RESET;
        end else if (rx_rst_q) begin
            ssel_q <= SDST_SSEL_NONE;
            saved_cnt_q <= ADDR_RESET;
        end else if (deselect && rx_if.active != 2'b00) begin
            saved_cnt_q <= rx_cnt_sel;
            if (ssel_q == SDST_SSEL_NONE) begin
                ssel_q <= rx_if.active[1] ? SDST_SSEL_B_ONCE : SDST_SSEL_A_ONCE;
            end else begin
                ssel_q <= rx_if.active[1] ? SDST_SSEL_B_MULTI : SDST_SSEL_A_MULTI;
            end
        end else if (rx_load != 2'b00) begin
            ssel_q <= SDST_SSEL_NONE;
        end
    end

    // Interrupt events: buffer unloads and a saved count
    assign irq_evt[IRQ_RX_UNLOAD_LSB +: 2] = rx_if.unload;
    assign irq_evt[IRQ_TX_UNLOAD_LSB +: 2] = tx_if.unload;
    assign irq_evt[IRQ_SSEL] = deselect & (rx_if.active != 2'b00) & ~rx_rst_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_stat_q <= '0;
        end else if (i_write && hit(i_addr, OFS_IRQ_STAT)) begin
            // A new event in the clearing cycle survives
            irq_stat_q <= (irq_stat_q & ~i_wdata[IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_mask_q <= '0;
        end else if (i_write && hit(i_addr, OFS_IRQ_MASK)) begin
            irq_mask_q <= i_wdata[IRQ_W-1:0];
        end
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    // Status word; every unnamed bit stays zero
    always_comb begin
        status = STATUS_RESET;
        status[ST_SSEL_LSB +: 3] = ssel_q;
        status[ST_FRM_LSB +: 2] = {err_flags[1][2], err_flags[0][2]};
        status[ST_PAR_LSB +: 2] = {err_flags[1][1], err_flags[0][1]};
        status[ST_OVF_LSB +: 2] = {err_flags[1][0], err_flags[0][0]};
        status[ST_TXACT_LSB +: 2] = tx_if.active;
        status[ST_RXACT_LSB +: 2] = rx_if.active;
    end

    // Read mux; unmapped addresses and the status register ignore writes
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(i_addr, OFS_STATUS)) begin
            rdata_d = status;
        end else if (hit(i_addr, OFS_CTRL)) begin
            rdata_d[CT_RX_LOAD_LSB +: 2] = rx_if.loaded;
            rdata_d[CT_TX_LOAD_LSB +: 2] = tx_if.loaded;
            rdata_d[CT_RX_RST] = rx_rst_q;
            rdata_d[CT_TX_RST] = tx_rst_q;
        end else if (hit(i_addr, OFS_RX_SAVED)) begin
            rdata_d[AW-1:0] = saved_cnt_q;
        end else if (hit(i_addr, OFS_IRQ_STAT)) begin
            rdata_d[IRQ_W-1:0] = irq_stat_q;
        end else if (hit(i_addr, OFS_IRQ_MASK)) begin
            rdata_d[IRQ_W-1:0] = irq_mask_q;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (hit(i_addr, OFS_RX_BEG[i])) begin
                    rdata_d = addr_word(rx_beg_q[i]);
                end
                if (hit(i_addr, OFS_RX_END[i])) begin
                    rdata_d = addr_word(rx_end_q[i]);
                end
                if (hit(i_addr, OFS_TX_BEG[i])) begin
                    rdata_d = addr_word(tx_beg_q[i]);
                end
                if (hit(i_addr, OFS_TX_END[i])) begin
                    rdata_d = addr_word(tx_end_q[i]);
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_read) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign o_rdata = rdata_q;
    assign o_rx_active = rx_if.active;
    assign o_tx_active = tx_if.active;
    assign o_rx_count = rx_cnt_sel;
    assign o_tx_count = tx_cnt_sel;
endmodule

// *** sdst_monitor.sv ***
// Concurrent checks on the serial DMA status tracker top ports.
// Assumes one clock domain; bound to every sdst_top instance below.
`timescale 1ns/10ps
module sdst_monitor
    import sdst_pkg::*;
#(
    parameter bit FIRST_CONTROLLER = 1'b1
) (
    // System
    input wire logic i_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [31:0] o_rdata,
    // FIFO side
    input wire logic i_rx_take,
    input wire logic i_rx_frame_err,
    input wire logic i_rx_parity_err,
    input wire logic i_rx_overrun,
    input wire logic i_tx_take,
    // Mode and pin
    input wire logic i_uart_mode,
    input wire logic i_spi_slave_mode,
    input wire logic i_slave_select_n,
    // Buffer state and interrupt
    input wire logic [1:0] o_rx_active,
    input wire logic [1:0] o_tx_active,
    input wire logic [AW-1:0] o_rx_count,
    input wire logic [AW-1:0] o_tx_count,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire logic st_rd = i_read && i_addr == OFS_STATUS;
    wire logic ctl_wr = i_write && i_addr == OFS_CTRL;

    a_status_unused_zero: assert property (st_rd |=> o_rdata[31:13] == '0)
        else $error("status unused bits not zero");
    a_save_code_legal: assert property (st_rd |=> !(o_rdata[12:10] inside {3'h1, 3'h4, 3'h5}))
        else $error("reserved save code seen");
    a_active_bits_match: assert property (st_rd |=> o_rdata[3:0] == {$past(o_tx_active), $past(o_rx_active)})
        else $error("status active bits differ from outputs");
    a_rx_reset_clears: assert property (ctl_wr && i_wdata[CT_RX_RST]
        |-> ##2 (o_rx_active == 2'b00 && o_rx_count == '0))
        else $error("receive reset left state behind");
    // A receive take with no buffer active must not move the receive count
    a_idle_take_ignored: assert property (o_rx_active == 2'b00 && i_rx_take && !i_write
        && !$past(i_write) |=> $stable(o_rx_count))
        else $error("take counted with no active buffer");
    a_take_counts_one: assert property ((o_rx_active != 2'b00) && i_rx_take && !i_write && !$past(i_write)
        |=> o_rx_active != $past(o_rx_active) || o_rx_count == $past(o_rx_count) + 1'b1)
        else $error("receive count did not advance by one");
    a_load_a_first: assert property (ctl_wr && i_wdata[1:0] != 2'b00 && !i_wdata[CT_RX_RST]
        && o_rx_active == 2'b00 && !$past(ctl_wr) |=> o_rx_active == ($past(i_wdata[0]) ? 2'b01 : 2'b10))
        else $error("wrong receive buffer made active");
    a_irq_mask_off: assert property (i_write && i_addr == OFS_IRQ_MASK && i_wdata[IRQ_W-1:0] == '0 |=> !o_irq)
        else $error("interrupt high with all sources masked");
    a_rdata_one_cycle: assert property (!i_read |=> o_rdata == '0)
        else $error("read data outside its cycle");

    c_error_take: cover property (i_rx_take && i_rx_frame_err && o_rx_active != 2'b00);
    c_deselect: cover property (i_spi_slave_mode && $rose(i_slave_select_n));
    c_irq_up: cover property ($rose(o_irq));
endmodule

bind sdst_top sdst_monitor #(.FIRST_CONTROLLER(FIRST_CONTROLLER)) sdst_monitor_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
    .i_read(i_read), .o_rdata(o_rdata), .i_rx_take(i_rx_take), .i_rx_frame_err(i_rx_frame_err),
    .i_rx_parity_err(i_rx_parity_err), .i_rx_overrun(i_rx_overrun), .i_tx_take(i_tx_take),
    .i_uart_mode(i_uart_mode), .i_spi_slave_mode(i_spi_slave_mode), .i_slave_select_n(i_slave_select_n),
    .o_rx_active(o_rx_active), .o_tx_active(o_tx_active), .o_rx_count(o_rx_count),
    .o_tx_count(o_tx_count), .o_irq(o_irq));

// *** sdst_fifo_model.sv ***
// Behavioural receive/transmit FIFO strobes and slave-select pin.
// Assumes one caller at a time; signals change just after a rising edge.
`timescale 1ns/10ps
module sdst_fifo_model (
    // System
    input wire logic i_clk,
    // Toward the tracker
    output logic o_rx_take,
    output logic o_rx_frame_err,
    output logic o_rx_parity_err,
    output logic o_rx_overrun,
    output logic o_tx_take,
    output logic o_slave_select_n
);
    initial begin
        o_rx_take = 1'b0;
        o_rx_frame_err = 1'b0;
        o_rx_parity_err = 1'b0;
        o_rx_overrun = 1'b0;
        o_tx_take = 1'b0;
        o_slave_select_n = 1'b1;
    end

    // Markings flip after the last byte so a stale marking is never trusted
    task automatic rx_bytes(input int n, input logic fe, input logic pe, input logic ov);
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            o_rx_take <= 1'b1;
            o_rx_frame_err <= fe;
            o_rx_parity_err <= pe;
            o_rx_overrun <= ov;
        end
        @(posedge i_clk);
        o_rx_take <= 1'b0;
        o_rx_frame_err <= ~fe;
        o_rx_parity_err <= ~pe;
        o_rx_overrun <= ~ov;
    endtask

    task automatic tx_bytes(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_tx_take <= 1'b1;
        end
        @(posedge i_clk);
        o_tx_take <= 1'b0;
    endtask

    // Select, hold, then release: one deassertion per call
    task automatic select_frame(input int hold);
        @(posedge i_clk);
        o_slave_select_n <= 1'b0;
        repeat (hold) @(posedge i_clk);
        o_slave_select_n <= 1'b1;
    endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the serial DMA status tracker.
// Assumes a 50 MHz clock; the FIFO model drives the stream side.
`timescale 1ns/10ps
module tb;
    import sdst_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [31:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic i_uart_mode = 1'b1;
    logic i_spi_slave_mode = 1'b0;
    logic [31:0] o_rdata;
    logic [1:0] o_rx_active;
    logic [1:0] o_tx_active;
    logic [AW-1:0] o_rx_count;
    logic [AW-1:0] o_tx_count;
    logic o_irq;
    logic rx_take, rx_fe, rx_pe, rx_ov, tx_take, ssel_n;
    int err_total = 0;
    int compares = 0;

    always #10 i_clk = ~i_clk;

    sdst_top sdst_top_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata), .i_rx_take(rx_take), .i_rx_frame_err(rx_fe),
        .i_rx_parity_err(rx_pe), .i_rx_overrun(rx_ov), .i_tx_take(tx_take), .i_uart_mode(i_uart_mode),
        .i_spi_slave_mode(i_spi_slave_mode), .i_slave_select_n(ssel_n), .o_rx_active(o_rx_active),
        .o_tx_active(o_tx_active), .o_rx_count(o_rx_count), .o_tx_count(o_tx_count), .o_irq(o_irq));

    sdst_fifo_model sdst_fifo_model_i (
        .i_clk(i_clk), .o_rx_take(rx_take), .o_rx_frame_err(rx_fe), .o_rx_parity_err(rx_pe),
        .o_rx_overrun(rx_ov), .o_tx_take(tx_take), .o_slave_select_n(ssel_n));

    task automatic final_report;
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_write <= 1'b0;
    endtask

    // Settle a few cycles, read, compare the word in its one valid cycle
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        repeat (4) @(posedge i_clk);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_read <= 1'b0;
        #1;
        chk_word(exp, o_rdata);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge i_clk);
        #1;
        chk_bit(exp, o_irq);
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        final_report;
    end

    initial begin
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        rd_chk(OFS_STATUS, 32'h0000_0000);
        rd_chk(OFS_TX_BEG[0], ADDR_FIXED);
        wr(OFS_TX_BEG[0], 32'hFFFF_FFFF);
        rd_chk(OFS_TX_BEG[0], 32'h2000_3FFF);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        rd_chk(32'h4000_C8FC, 32'h0000_0000);
        sdst_fifo_model_i.rx_bytes(1, 1'b1, 1'b1, 1'b1);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        wr(OFS_RX_END[0], 32'h0000_0003);
        wr(OFS_RX_END[1], 32'h0000_0003);
        wr(OFS_CTRL, 32'h0000_0003);
        rd_chk(OFS_STATUS, 32'h0000_0001);
        rd_chk(OFS_CTRL, 32'h0000_0003);
        sdst_fifo_model_i.rx_bytes(1, 1'b1, 1'b0, 1'b0);
        sdst_fifo_model_i.rx_bytes(1, 1'b0, 1'b1, 1'b0);
        rd_chk(OFS_STATUS, 32'h0000_0141);
        // Fourth byte pushes the count past the end address
        sdst_fifo_model_i.rx_bytes(2, 1'b0, 1'b0, 1'b0);
        rd_chk(OFS_STATUS, 32'h0000_0142);
        rd_chk(OFS_IRQ_STAT, 32'h0000_0001);
        irq_chk(1'b0);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        irq_chk(1'b1);
        wr(OFS_IRQ_STAT, 32'h0000_0001);
        irq_chk(1'b0);
        sdst_fifo_model_i.rx_bytes(1, 1'b0, 1'b0, 1'b1);
        rd_chk(OFS_STATUS, 32'h0000_0162);
        wr(OFS_CTRL, 32'h0000_0001);
        rd_chk(OFS_STATUS, 32'h0000_0022);
        @(posedge i_clk);
        i_spi_slave_mode <= 1'b1;
        sdst_fifo_model_i.select_frame(3);
        rd_chk(OFS_STATUS, 32'h0000_0C22);
        rd_chk(OFS_RX_SAVED, 32'h0000_0001);
        sdst_fifo_model_i.select_frame(3);
        rd_chk(OFS_STATUS, 32'h0000_1C22);
        wr(OFS_CTRL, 32'h0000_0001);
        rd_chk(OFS_STATUS, 32'h0000_0022);
        sdst_fifo_model_i.select_frame(3);
        wr(OFS_CTRL, 32'h0000_0010);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        rd_chk(OFS_CTRL, 32'h0000_0000);
        @(posedge i_clk);
        i_uart_mode <= 1'b0;
        wr(OFS_CTRL, 32'h0000_0001);
        sdst_fifo_model_i.rx_bytes(1, 1'b1, 1'b1, 1'b0);
        rd_chk(OFS_STATUS, 32'h0000_0001);
        chk_word(32'h0000_0001, 32'(o_rx_count));
        // Buffer A active: a deselect saves A's count once
        sdst_fifo_model_i.select_frame(3);
        rd_chk(OFS_STATUS, 32'h0000_0801);
        // Outside slave mode a deselect must not count again
        @(posedge i_clk);
        i_spi_slave_mode <= 1'b0;
        sdst_fifo_model_i.select_frame(3);
        rd_chk(OFS_STATUS, 32'h0000_0801);
        wr(OFS_TX_BEG[0], 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_000C);
        rd_chk(OFS_STATUS, 32'h0000_0805);
        sdst_fifo_model_i.tx_bytes(1);
        rd_chk(OFS_STATUS, 32'h0000_0809);
        chk_word(32'h0000_0000, 32'(o_tx_count));
        sdst_fifo_model_i.tx_bytes(1);
        rd_chk(OFS_STATUS, 32'h0000_0801);
        // Transmit reset drops loaded transmit buffers, receive side untouched
        wr(OFS_CTRL, 32'h0000_000C);
        wr(OFS_CTRL, 32'h0000_0020);
        rd_chk(OFS_STATUS, 32'h0000_0801);
        wr(OFS_IRQ_MASK, 32'h0000_001F);
        irq_chk(1'b1);
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        irq_chk(1'b0);
        final_report;
    end
endmodule
